/* File: hdl/aux_line_driver.sv */
// Auxiliary output line driver and peripheral control register
`timescale 1ns/1ps
`default_nettype none
module aux_line_driver
	import pport_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk_in,
	input wire logic rst_in,
	// Control write
	input wire logic ctl_wr_in,
	input wire logic [7:0] ctl_data_in,
	// Outputs
	output logic aux_out_zero_out,
	output logic aux_out_one_out,
	output logic check_en_out
);

	typedef struct packed {
		logic aux_zero;
		logic aux_one;
		logic check_en;
	} aux_state_type;

	aux_state_type state_reg;
	aux_state_type state_next;

	// No interface-reset input: lines keep their level across it
	always_comb
	begin
		state_next = state_reg;
		if (ctl_wr_in)
		begin
			state_next.aux_zero = ~ctl_data_in[CTL_AUX_ZERO_BIT];
			state_next.aux_one = ~ctl_data_in[CTL_AUX_ONE_BIT];
			state_next.check_en = ctl_data_in[CTL_CHECK_EN_BIT];
		end
	end

	always_ff @(posedge sys_clk_in)
	begin
		if (rst_in)
		begin
			state_reg.aux_zero <= AUX_LEVEL_RESET;
			state_reg.aux_one <= AUX_LEVEL_RESET;
			state_reg.check_en <= CHECK_EN_RESET;
		end
		else
		begin
			state_reg <= state_next;
		end
	end

	assign aux_out_zero_out = state_reg.aux_zero;
	assign aux_out_one_out = state_reg.aux_one;
	assign check_en_out = state_reg.check_en;

endmodule : aux_line_driver
`default_nettype wire

/* File: hdl/handshake_engine.sv */
// Handshake request line sequencer for full and pulse modes
`timescale 1ns/1ps
`default_nettype none
module handshake_engine
	import pport_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk_in,
	input wire logic rst_in,
	// Control
	input wire logic clear_in,
	input wire logic kick_in,
	input wire logic full_mode_in,
	input wire logic peripheral_flag_line_in,
	// Line
	output logic handshake_request_line_out
);

	typedef enum logic [2:0] {
		HS_IDLE = 3'b001,
		HS_FULL = 3'b010,
		HS_PULSE = 3'b100
	} hs_phase_type;

	typedef struct packed {
		hs_phase_type phase;
		logic [7:0] count;
		logic line;
	} hs_state_type;

	hs_state_type state_reg;
	hs_state_type state_next;

	always_comb
	begin
		state_next = state_reg;
		case (state_reg.phase)
			HS_IDLE:
			begin
				if (kick_in)
				begin
					state_next.line = 1'b1;
					state_next.count = PULSE_CYCLES;
					state_next.phase = full_mode_in ? HS_FULL : HS_PULSE;
				end
			end
			HS_FULL:
			begin
				// Peripheral going busy acknowledges the request
				if (!peripheral_flag_line_in)
				begin
					state_next.line = 1'b0;
					state_next.phase = HS_IDLE;
				end
			end
			HS_PULSE:
			begin
				state_next.count = state_reg.count - 8'h01;
				if (state_reg.count == 8'h01)
				begin
					state_next.line = 1'b0;
					state_next.phase = HS_IDLE;
				end
			end
			default:
			begin
				state_next.line = 1'b0;
				state_next.phase = HS_IDLE;
			end
		endcase
		if (clear_in)
		begin
			state_next.line = 1'b0;
			state_next.phase = HS_IDLE;
			state_next.count = 8'h00;
		end
	end

	always_ff @(posedge sys_clk_in)
	begin
		if (rst_in)
		begin
			state_reg.phase <= HS_IDLE;
			state_reg.count <= 8'h00;
			state_reg.line <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
		end
	end

	assign handshake_request_line_out = state_reg.line;

endmodule : handshake_engine
`default_nettype wire

/* File: hdl/parallel_port_aux_lines_regs.sv */
// Parallel peripheral port register file, auxiliary lines and health check
//
// Behaviour
// - Control bit 0/1 set drives aux_out_zero/aux_out_one low; clear drives high.
// - Aux output polarity fixed; level held until rewritten; interface reset ignores it.
// - Status bits 0/1 read 1 when aux_in_zero/aux_in_one are low.
// - Peripheral status returns live aux input levels, never latched.
// - Status bit 3 is peripheral ok, bit 2 is interrupt line low, 7-4 zero.
// - Health check before transfers is off by default, on via control bit 2.
// - Failed check reports error 172 with no interrupt and no timeout.
// - Status register 0 returns a fixed card identity code.
// - Write with non-zero low byte to control register 0 resets the interface; zero low byte does nothing.
// - Status register 1 shows interrupt, level switch and DMA state bits.
// - Write with non-zero low byte to control register 1 sets the handshake request line.
// - Status register 4 reads 1 when ready for a transfer, 0 when busy.
// - Control register 3 takes data-out word; status register 3 returns data-in word.
// - Full mode ready needs flag ready and request clear; pulse mode request only.
`timescale 1ns/1ps
`default_nettype none
module parallel_port_aux_lines_regs
	import pport_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk_in,
	input wire logic rst_in,
	// Host register port
	input wire logic [2:0] reg_addr_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [15:0] reg_wdata_in,
	output logic [15:0] reg_rdata_out,
	output logic reg_rvalid_out,
	// Card straps and interrupt/DMA state
	input wire logic full_mode_in,
	input wire logic irq_enabled_in,
	input wire logic irq_requested_in,
	input wire logic [1:0] irq_level_in,
	input wire logic burst_dma_in,
	input wire logic word_dma_in,
	input wire logic dma_ch1_en_in,
	input wire logic dma_ch0_en_in,
	// Peripheral lines
	input wire logic aux_in_zero_in,
	input wire logic aux_in_one_in,
	input wire logic peripheral_ok_line_in,
	input wire logic external_interrupt_request_in,
	input wire logic peripheral_flag_line_in,
	input wire logic [15:0] data_in_lines_in,
	output logic [15:0] data_out_lines_out,
	output logic aux_out_zero_out,
	output logic aux_out_one_out,
	output logic handshake_request_line_out,
	// Error report
	output logic periph_error_out,
	output logic [7:0] periph_error_code_out
);

	typedef struct packed {
		logic [15:0] rdata;
		logic rvalid;
		logic [15:0] data_out;
		logic [15:0] data_in;
		logic perr;
		logic kick;
		logic if_reset;
		logic [7:0] err_code;
	} top_state_type;

	top_state_type state_reg;
	top_state_type state_next;

	logic check_en;
	logic hs_line;
	logic ready;
	logic [7:0] periph_status;
	logic [7:0] irq_dma_status;
	logic [7:0] xfer_state;
	logic wr_ctl;

	assign wr_ctl = reg_wr_in && (reg_addr_in == ADDR_PERIPHERAL_CONTROL);

	// Only the low three bits reach the driver; the rest are dropped
	aux_line_driver u_aux (
		.sys_clk_in(sys_clk_in),
		.rst_in(rst_in),
		.ctl_wr_in(wr_ctl),
		.ctl_data_in({5'h00, reg_wdata_in[2:0]}),
		.aux_out_zero_out(aux_out_zero_out),
		.aux_out_one_out(aux_out_one_out),
		.check_en_out(check_en)
	);

	handshake_engine u_hs (
		.sys_clk_in(sys_clk_in),
		.rst_in(rst_in),
		.clear_in(state_reg.if_reset),
		.kick_in(state_reg.kick),
		.full_mode_in(full_mode_in),
		.peripheral_flag_line_in(peripheral_flag_line_in),
		.handshake_request_line_out(hs_line)
	);

	// Ready also waits for a queued request so a back-to-back poll sees busy
	assign ready = !hs_line && !state_reg.kick && (!full_mode_in || peripheral_flag_line_in);

	// Inputs read live, combined straight into the read word
	always_comb
	begin
		periph_status = 8'h00;
		periph_status[STS_AUX_ZERO_BIT] = ~aux_in_zero_in;
		periph_status[STS_AUX_ONE_BIT] = ~aux_in_one_in;
		periph_status[STS_EIR_LOW_BIT] = ~external_interrupt_request_in;
		periph_status[STS_OK_BIT] = peripheral_ok_line_in;
	end

	assign irq_dma_status = {irq_enabled_in, irq_requested_in, irq_level_in,
		burst_dma_in, word_dma_in, dma_ch1_en_in, dma_ch0_en_in};

	always_comb
	begin
		xfer_state = 8'h00;
		xfer_state[XFER_IRQ_EN_BIT] = irq_enabled_in;
		xfer_state[XFER_HS_BUSY_BIT] = hs_line;
	end

	always_comb
	begin
		state_next = state_reg;
		state_next.rvalid = 1'b0;
		state_next.perr = 1'b0;
		state_next.kick = 1'b0;
		state_next.if_reset = 1'b0;
		state_next.err_code = PERIPH_ERROR_CODE;
		if (reg_rd_in)
		begin
			state_next.rvalid = 1'b1;
			case (reg_addr_in)
				ADDR_CARD_IDENTITY: state_next.rdata = {8'h00, CARD_ID_VALUE};
				ADDR_INTERRUPT_DMA_STATUS: state_next.rdata = {8'h00, irq_dma_status};
				ADDR_TRANSFER_STATE: state_next.rdata = {8'h00, xfer_state};
				ADDR_DATA_IN_WORD:
				begin
					// Reading clocks the lines into the input register
					state_next.data_in = data_in_lines_in;
					state_next.rdata = data_in_lines_in;
				end
				ADDR_INTERFACE_READY_FLAG: state_next.rdata = {15'h0000, ready};
				ADDR_PERIPHERAL_STATUS: state_next.rdata = {8'h00, periph_status};
				default: state_next.rdata = 16'h0000;
			endcase
		end
		if (reg_wr_in)
		begin
			case (reg_addr_in)
				ADDR_INTERFACE_RESET:
				begin
					if (reg_wdata_in[7:0] != 8'h00)
					begin
						state_next.if_reset = 1'b1;
					end
				end
				ADDR_HANDSHAKE_REQUEST_SET:
				begin
					if (reg_wdata_in[7:0] != 8'h00)
					begin
						// Failed check blocks the handshake; no interrupt or timer involved
						if (check_en && !peripheral_ok_line_in)
						begin
							state_next.perr = 1'b1;
						end
						else
						begin
							state_next.kick = 1'b1;
						end
					end
				end
				ADDR_DATA_OUT_WORD: state_next.data_out = reg_wdata_in;
				default: state_next.data_out = state_next.data_out;
			endcase
		end
		if (state_reg.if_reset)
		begin
			state_next.data_out = DATA_OUT_RESET;
			state_next.kick = 1'b0;
		end
	end

	always_ff @(posedge sys_clk_in)
	begin
		if (rst_in)
		begin
			state_reg.rdata <= 16'h0000;
			state_reg.rvalid <= 1'b0;
			state_reg.data_out <= DATA_OUT_RESET;
			state_reg.data_in <= 16'h0000;
			state_reg.perr <= 1'b0;
			state_reg.kick <= 1'b0;
			state_reg.if_reset <= 1'b0;
			state_reg.err_code <= PERIPH_ERROR_CODE;
		end
		else
		begin
			state_reg <= state_next;
		end
	end

	assign reg_rdata_out = state_reg.rdata;
	assign reg_rvalid_out = state_reg.rvalid;
	assign data_out_lines_out = state_reg.data_out;
	assign periph_error_out = state_reg.perr;
	assign periph_error_code_out = state_reg.err_code;
	assign handshake_request_line_out = hs_line;

	property p_aux_zero_level;
		@(posedge sys_clk_in) disable iff (rst_in)
		wr_ctl |=> (aux_out_zero_out == !$past(reg_wdata_in[CTL_AUX_ZERO_BIT]));
	endproperty
	a_aux_zero_level: assert property (p_aux_zero_level)
		else $error("aux_out_zero level does not follow control bit 0");

	property p_aux_one_level;
		@(posedge sys_clk_in) disable iff (rst_in)
		wr_ctl |=> (aux_out_one_out == !$past(reg_wdata_in[CTL_AUX_ONE_BIT]));
	endproperty
	a_aux_one_level: assert property (p_aux_one_level)
		else $error("aux_out_one level does not follow control bit 1");

	property p_aux_hold;
		@(posedge sys_clk_in) disable iff (rst_in)
		!wr_ctl |=> $stable(aux_out_zero_out) && $stable(aux_out_one_out);
	endproperty
	a_aux_hold: assert property (p_aux_hold)
		else $error("aux output changed without a control write");

	property p_status_live;
		@(posedge sys_clk_in) disable iff (rst_in)
		(reg_rd_in && reg_addr_in == ADDR_PERIPHERAL_STATUS) |=>
			reg_rvalid_out && reg_rdata_out[15:4] == 12'h000 &&
			reg_rdata_out[0] == !$past(aux_in_zero_in) &&
			reg_rdata_out[1] == !$past(aux_in_one_in) &&
			reg_rdata_out[2] == !$past(external_interrupt_request_in) &&
			reg_rdata_out[3] == $past(peripheral_ok_line_in);
	endproperty
	a_status_live: assert property (p_status_live)
		else $error("peripheral status word does not match the lines");

	property p_card_id;
		@(posedge sys_clk_in) disable iff (rst_in)
		(reg_rd_in && reg_addr_in == ADDR_CARD_IDENTITY) |=>
			reg_rdata_out == {8'h00, CARD_ID_VALUE};
	endproperty
	a_card_id: assert property (p_card_id)
		else $error("card identity read returned a wrong value");

	property p_check_error;
		@(posedge sys_clk_in) disable iff (rst_in)
		(reg_wr_in && reg_addr_in == ADDR_HANDSHAKE_REQUEST_SET && reg_wdata_in[7:0] != 8'h00
			&& check_en && !peripheral_ok_line_in && !state_reg.if_reset)
			|=> periph_error_out && !state_reg.kick ##1 !periph_error_out;
	endproperty
	a_check_error: assert property (p_check_error)
		else $error("failed health check did not give a one-cycle error");

	property p_no_check;
		@(posedge sys_clk_in) disable iff (rst_in)
		!check_en |=> !periph_error_out;
	endproperty
	a_no_check: assert property (p_no_check)
		else $error("error reported while the health check is off");

	property p_hs_set;
		@(posedge sys_clk_in) disable iff (rst_in)
		(reg_wr_in && reg_addr_in == ADDR_HANDSHAKE_REQUEST_SET && reg_wdata_in[7:0] != 8'h00
			&& !check_en && !hs_line && !state_reg.if_reset) |=> ##1 hs_line;
	endproperty
	a_hs_set: assert property (p_hs_set)
		else $error("handshake request line not set two cycles after write");

	property p_reset_clears;
		@(posedge sys_clk_in) disable iff (rst_in)
		(reg_wr_in && reg_addr_in == ADDR_INTERFACE_RESET && reg_wdata_in[7:0] != 8'h00)
			|=> ##1 !hs_line && data_out_lines_out == DATA_OUT_RESET;
	endproperty
	a_reset_clears: assert property (p_reset_clears)
		else $error("interface reset did not clear handshake and data out");

	property p_ready_read;
		@(posedge sys_clk_in) disable iff (rst_in)
		(reg_rd_in && reg_addr_in == ADDR_INTERFACE_READY_FLAG) |=>
			reg_rdata_out == {15'h0000, $past(!hs_line && !state_reg.kick &&
				(!full_mode_in || peripheral_flag_line_in))};
	endproperty
	a_ready_read: assert property (p_ready_read)
		else $error("ready read does not match request line and flag");

	property p_data_out;
		@(posedge sys_clk_in) disable iff (rst_in)
		(reg_wr_in && reg_addr_in == ADDR_DATA_OUT_WORD && !state_reg.if_reset) |=>
			data_out_lines_out == $past(reg_wdata_in);
	endproperty
	a_data_out: assert property (p_data_out)
		else $error("data out lines do not carry the written word");

	property p_irq_dma_read;
		@(posedge sys_clk_in) disable iff (rst_in)
		(reg_rd_in && reg_addr_in == ADDR_INTERRUPT_DMA_STATUS) |=>
			reg_rdata_out == {8'h00, $past(irq_enabled_in), $past(irq_requested_in),
				$past(irq_level_in), $past(burst_dma_in), $past(word_dma_in),
				$past(dma_ch1_en_in), $past(dma_ch0_en_in)};
	endproperty
	a_irq_dma_read: assert property (p_irq_dma_read)
		else $error("interrupt and DMA status word does not match the inputs");

	property p_data_in_read;
		@(posedge sys_clk_in) disable iff (rst_in)
		(reg_rd_in && reg_addr_in == ADDR_DATA_IN_WORD) |=>
			reg_rdata_out == $past(data_in_lines_in);
	endproperty
	a_data_in_read: assert property (p_data_in_read)
		else $error("data in read does not return the data lines");

	property p_zero_request;
		@(posedge sys_clk_in) disable iff (rst_in)
		(reg_wr_in && reg_addr_in == ADDR_HANDSHAKE_REQUEST_SET && reg_wdata_in[7:0] == 8'h00)
			|=> !state_reg.kick && !periph_error_out;
	endproperty
	a_zero_request: assert property (p_zero_request)
		else $error("zero request write started a handshake or an error");

	property p_zero_reset;
		@(posedge sys_clk_in) disable iff (rst_in)
		(reg_wr_in && reg_addr_in == ADDR_INTERFACE_RESET && reg_wdata_in[7:0] == 8'h00)
			|=> !state_reg.if_reset;
	endproperty
	a_zero_reset: assert property (p_zero_reset)
		else $error("zero reset write reset the interface");

	property p_error_code;
		@(posedge sys_clk_in) disable iff (rst_in)
		periph_error_out |-> periph_error_code_out == PERIPH_ERROR_CODE;
	endproperty
	a_error_code: assert property (p_error_code)
		else $error("peripheral error shown with a wrong code");

	property p_reset_keeps_check;
		@(posedge sys_clk_in) disable iff (rst_in)
		(state_reg.if_reset && !wr_ctl) |=> $stable(check_en);
	endproperty
	a_reset_keeps_check: assert property (p_reset_keeps_check)
		else $error("interface reset changed the health check enable");

endmodule : parallel_port_aux_lines_regs
`default_nettype wire

/* File: hdl/pport_pkg.sv */
// Package: register map, field positions, reset values and timing counts
package pport_pkg;

	// Register indices (status side on read, control side on write)
	localparam logic [2:0] ADDR_CARD_IDENTITY = 3'h0;
	localparam logic [2:0] ADDR_INTERFACE_RESET = 3'h0;
	localparam logic [2:0] ADDR_INTERRUPT_DMA_STATUS = 3'h1;
	localparam logic [2:0] ADDR_HANDSHAKE_REQUEST_SET = 3'h1;
	localparam logic [2:0] ADDR_TRANSFER_STATE = 3'h2;
	localparam logic [2:0] ADDR_PERIPHERAL_CONTROL = 3'h2;
	localparam logic [2:0] ADDR_DATA_IN_WORD = 3'h3;
	localparam logic [2:0] ADDR_DATA_OUT_WORD = 3'h3;
	localparam logic [2:0] ADDR_INTERFACE_READY_FLAG = 3'h4;
	localparam logic [2:0] ADDR_PERIPHERAL_STATUS = 3'h5;

	// Card identity, value arbitrary
	localparam logic [7:0] CARD_ID_VALUE = 8'h5A;

	// Peripheral control fields
	localparam int CTL_AUX_ZERO_BIT = 0;
	localparam int CTL_AUX_ONE_BIT = 1;
	localparam int CTL_CHECK_EN_BIT = 2;

	// Peripheral status fields
	localparam int STS_AUX_ZERO_BIT = 0;
	localparam int STS_AUX_ONE_BIT = 1;
	localparam int STS_EIR_LOW_BIT = 2;
	localparam int STS_OK_BIT = 3;

	// Transfer state fields
	localparam int XFER_IRQ_EN_BIT = 1;
	localparam int XFER_HS_BUSY_BIT = 2;

	// Reset values
	localparam logic AUX_LEVEL_RESET = 1'b1;
	localparam logic CHECK_EN_RESET = 1'b0;
	localparam logic [15:0] DATA_OUT_RESET = 16'h0000;

	// Peripheral error code reported on a failed health check
	localparam logic [7:0] PERIPH_ERROR_CODE = 8'hAC;

	// Pulse-mode handshake request width
	localparam int CLK_PERIOD_PS = 25000;
	localparam int PULSE_WIDTH_PS = 100000;
	localparam int PULSE_CYCLES_RAW = (PULSE_WIDTH_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam logic [7:0] PULSE_CYCLES = 8'(PULSE_CYCLES_RAW < 1 ? 1 : PULSE_CYCLES_RAW);

endpackage : pport_pkg

/* File: verif/periph_model.sv */
// Peripheral model: answers the handshake request line with a busy flag pulse
`timescale 1ns/1ps
`default_nettype none
module periph_model
(
	// Clock and reset
	input wire logic sys_clk_in,
	input wire logic rst_in,
	// Bench controls: response delay and a forced busy hold
	input wire logic [7:0] delay_in,
	input wire logic stall_in,
	// Port side
	input wire logic handshake_request_line_in,
	output logic peripheral_flag_line_out
);
	logic [7:0] cnt_reg;
	logic [1:0] phase_reg;
	// Rearms only once the request clears, so one request gives one busy pulse
	always @(posedge sys_clk_in)
	begin
		if (rst_in)
		begin
			cnt_reg <= 8'h00;
			phase_reg <= 2'h0;
		end
		else
		begin
			case (phase_reg)
				2'h0: if (handshake_request_line_in)
				begin
					cnt_reg <= delay_in;
					phase_reg <= 2'h1;
				end
				2'h1: if (cnt_reg == 8'h00)
				begin
					cnt_reg <= 8'h02;
					phase_reg <= 2'h2;
				end
				else
					cnt_reg <= cnt_reg - 8'h01;
				2'h2: if (cnt_reg == 8'h00)
					phase_reg <= 2'h3;
				else
					cnt_reg <= cnt_reg - 8'h01;
				default: if (!handshake_request_line_in)
					phase_reg <= 2'h0;
			endcase
		end
	end
	assign peripheral_flag_line_out = !stall_in && (phase_reg != 2'h2);
endmodule : periph_model
`default_nettype wire

/* File: verif/tb_top.sv */
// Testbench: register port, auxiliary lines, handshake and health check
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import pport_pkg::*;
	logic sys_clk_in, rst_in, reg_wr_in, reg_rd_in, reg_rvalid_out, full_mode_in;
	logic [2:0] reg_addr_in;
	logic [15:0] reg_wdata_in, reg_rdata_out, data_in_lines_in, data_out_lines_out;
	logic irq_enabled_in, irq_requested_in, burst_dma_in, word_dma_in, dma_ch1_en_in;
	logic dma_ch0_en_in, aux_in_zero_in, aux_in_one_in, peripheral_ok_line_in;
	logic external_interrupt_request_in, peripheral_flag_line_in, aux_out_zero_out;
	logic aux_out_one_out, handshake_request_line_out, periph_error_out, stall;
	logic [1:0] irq_level_in;
	logic [7:0] periph_error_code_out, delay;
	logic [31:0] rnd;
	logic [15:0] expq[$];
	int miscompares, checked, err_cnt, e0, n;

	parallel_port_aux_lines_regs u_parallel_port_aux_lines_regs (.sys_clk_in, .rst_in,
		.reg_addr_in, .reg_wr_in, .reg_rd_in, .reg_wdata_in, .reg_rdata_out, .reg_rvalid_out,
		.full_mode_in, .irq_enabled_in, .irq_requested_in, .irq_level_in, .burst_dma_in,
		.word_dma_in, .dma_ch1_en_in, .dma_ch0_en_in, .aux_in_zero_in, .aux_in_one_in,
		.peripheral_ok_line_in, .external_interrupt_request_in, .peripheral_flag_line_in,
		.data_in_lines_in, .data_out_lines_out, .aux_out_zero_out, .aux_out_one_out,
		.handshake_request_line_out, .periph_error_out, .periph_error_code_out);
	periph_model u_periph_model (.sys_clk_in, .rst_in, .delay_in(delay), .stall_in(stall),
		.handshake_request_line_in(handshake_request_line_out),
		.peripheral_flag_line_out(peripheral_flag_line_in));

	initial
	begin
		sys_clk_in = 1'b0;
		forever #12.5 sys_clk_in = ~sys_clk_in;
	end

	task automatic give_verdict;
		$display("Comparisons %0d, mismatches %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : give_verdict

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	function automatic logic [31:0] xorshift(input logic [31:0] v);
		logic [31:0] t;
		t = v ^ (v << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction : xorshift

	task automatic nx;
		rnd = xorshift(rnd);
	endtask : nx

	task automatic rd(input logic [2:0] a, input logic [15:0] exp);
		@(posedge sys_clk_in);
		reg_rd_in <= 1'b1;
		reg_addr_in <= a;
		expq.push_back(exp);
		@(posedge sys_clk_in);
		reg_rd_in <= 1'b0;
	endtask : rd

	task automatic wr(input logic [2:0] a, input logic [15:0] d);
		@(posedge sys_clk_in);
		reg_wr_in <= 1'b1;
		reg_addr_in <= a;
		reg_wdata_in <= d;
		@(posedge sys_clk_in);
		reg_wr_in <= 1'b0;
		@(negedge sys_clk_in);
	endtask : wr

	// Bounded wait for the request line; an expired wait ends the run
	task automatic wait_line(input logic v);
		int k;
		k = 0;
		@(posedge sys_clk_in);
		while (handshake_request_line_out !== v && k < 80)
		begin
			k++;
			@(posedge sys_clk_in);
		end
		if (k == 80)
		begin
			miscompares++;
			$display("Error at %0t: request line wait expired", $time);
			give_verdict();
		end
	endtask : wait_line

	// Read answers are matched in order against the noted expectations
	always @(posedge sys_clk_in)
	begin
		if (reg_rvalid_out === 1'b1)
		begin
			if (expq.size() == 0)
				chk(reg_rdata_out, 16'hFFFF ^ reg_rdata_out);
			else
				chk(reg_rdata_out, expq.pop_front());
		end
		if (periph_error_out === 1'b1)
			err_cnt++;
	end

	initial
	begin
		rnd = 32'h262d;
		{rst_in, full_mode_in, peripheral_ok_line_in, external_interrupt_request_in} = 4'hF;
		{reg_wr_in, reg_rd_in, reg_addr_in, reg_wdata_in, data_in_lines_in} = '0;
		{irq_enabled_in, irq_requested_in, irq_level_in, burst_dma_in} = '0;
		{word_dma_in, dma_ch1_en_in, dma_ch0_en_in, aux_in_zero_in, aux_in_one_in} = '0;
		{stall, delay, miscompares, checked, err_cnt} = '0;
		delay = 8'h06;
		repeat (12) @(posedge sys_clk_in);
		rst_in <= 1'b0;
		@(negedge sys_clk_in);
		chk({aux_out_zero_out, aux_out_one_out, handshake_request_line_out}, 16'h6);
		rd(ADDR_CARD_IDENTITY, {8'h00, CARD_ID_VALUE});
		nx();
		@(posedge sys_clk_in);
		{irq_enabled_in, irq_requested_in, irq_level_in, burst_dma_in} <= rnd[4:0];
		{word_dma_in, dma_ch1_en_in, dma_ch0_en_in} <= rnd[7:5];
		rd(ADDR_INTERRUPT_DMA_STATUS, {8'h00, rnd[4:0], rnd[7:5]});
		rd(3'h6, 16'h0000);
		rd(3'h7, 16'h0000);
		for (int i = 0; i < 4; i++)
		begin
			nx();
			wr(ADDR_PERIPHERAL_CONTROL, {rnd[15:3], 1'b0, i[1:0]});
			chk({aux_out_one_out, aux_out_zero_out}, {14'h0, ~i[1:0]});
		end
		for (int i = 0; i < 8; i++)
		begin
			nx();
			@(posedge sys_clk_in);
			{aux_in_zero_in, aux_in_one_in} <= rnd[1:0];
			{peripheral_ok_line_in, external_interrupt_request_in} <= rnd[3:2];
			rd(ADDR_PERIPHERAL_STATUS, {12'h0, rnd[3], ~rnd[2], ~rnd[0], ~rnd[1]});
		end
		peripheral_ok_line_in <= 1'b1;
		nx();
		data_in_lines_in <= rnd[31:16];
		wr(ADDR_DATA_OUT_WORD, rnd[15:0]);
		chk(data_out_lines_out, rnd[15:0]);
		rd(ADDR_DATA_IN_WORD, rnd[31:16]);
		wr(ADDR_HANDSHAKE_REQUEST_SET, 16'hFF00);
		repeat (3) @(negedge sys_clk_in);
		chk(handshake_request_line_out, 16'h0);
		wr(ADDR_HANDSHAKE_REQUEST_SET, 16'h0001);
		wait_line(1'b1);
		rd(ADDR_TRANSFER_STATE, {13'h0, 1'b1, irq_enabled_in, 1'b0});
		rd(ADDR_INTERFACE_READY_FLAG, 16'h0000);
		wait_line(1'b0);
		repeat (6) @(posedge sys_clk_in);
		rd(ADDR_INTERFACE_READY_FLAG, 16'h0001);
		stall <= 1'b1;
		rd(ADDR_INTERFACE_READY_FLAG, 16'h0000);
		full_mode_in <= 1'b0;
		rd(ADDR_INTERFACE_READY_FLAG, 16'h0001);
		stall <= 1'b0;
		wr(ADDR_HANDSHAKE_REQUEST_SET, 16'h0080);
		wait_line(1'b1);
		n = 1;
		@(posedge sys_clk_in);
		while (handshake_request_line_out === 1'b1 && n < 40)
		begin
			n++;
			@(posedge sys_clk_in);
		end
		chk(16'(n), {8'h00, PULSE_CYCLES});
		full_mode_in <= 1'b1;
		delay <= 8'h28;
		repeat (60) @(posedge sys_clk_in);
		wr(ADDR_HANDSHAKE_REQUEST_SET, 16'h0001);
		wait_line(1'b1);
		wr(ADDR_INTERFACE_RESET, 16'hFF00);
		repeat (2) @(negedge sys_clk_in);
		chk(handshake_request_line_out, 16'h1);
		chk(data_out_lines_out, rnd[15:0]);
		wr(ADDR_INTERFACE_RESET, 16'h0001);
		repeat (2) @(negedge sys_clk_in);
		chk(handshake_request_line_out, 16'h0);
		chk(data_out_lines_out, DATA_OUT_RESET);
		chk({aux_out_zero_out, aux_out_one_out}, 16'h0);
		delay <= 8'h06;
		repeat (60) @(posedge sys_clk_in);
		e0 = err_cnt;
		peripheral_ok_line_in <= 1'b0;
		wr(ADDR_HANDSHAKE_REQUEST_SET, 16'h0001);
		wait_line(1'b1);
		chk(16'(err_cnt), 16'(e0));
		wait_line(1'b0);
		repeat (8) @(posedge sys_clk_in);
		wr(ADDR_PERIPHERAL_CONTROL, 16'h0004);
		wr(ADDR_HANDSHAKE_REQUEST_SET, 16'h0001);
		repeat (6) @(negedge sys_clk_in);
		chk(16'(err_cnt), 16'(e0 + 1));
		chk({handshake_request_line_out, periph_error_code_out}, 16'h00AC);
		chk({aux_out_zero_out, aux_out_one_out}, 16'h3);
		peripheral_ok_line_in <= 1'b1;
		wr(ADDR_HANDSHAKE_REQUEST_SET, 16'h0001);
		wait_line(1'b1);
		chk(16'(err_cnt), 16'(e0 + 1));
		wait_line(1'b0);
		rd(ADDR_CARD_IDENTITY, {8'h00, CARD_ID_VALUE});
		repeat (3) @(posedge sys_clk_in);
		chk(16'(expq.size()), 16'h0);
		give_verdict();
	end
endmodule : tb_top
`default_nettype wire
